// *** hw/msrg_defs.vh ***
`ifndef MSRG_DEFS_VH
`define MSRG_DEFS_VH

// Register byte offsets
`define MSRG_CTRL       12'h000
`define MSRG_DLY_MIN    12'h004
`define MSRG_DLY_MAX    12'h008
`define MSRG_SHAPE      12'h00c
`define MSRG_PULSE_W    12'h010
`define MSRG_CODE       12'h014
`define MSRG_ALT25      12'h018
`define MSRG_GRAY       12'h01c
`define MSRG_ADDR       12'h020
`define MSRG_IDENT      12'h024
`define MSRG_SEL        12'h028
`define MSRG_STATUS     12'h02c
`define MSRG_TRIG       12'h030
`define MSRG_RAW        12'h040
`define MSRG_BAD        12'h080
`define MSRG_STORE      12'h100
`define MSRG_STORE_END  12'h190

// Write masks, reserved bits read as zero
`define MSRG_M_CTRL     32'h0000_01ff
`define MSRG_M_DLY      32'h0000_3fff
`define MSRG_M_SHAPE    32'h0000_fdff
`define MSRG_M_CODE     32'h0000_0fff
`define MSRG_M_ALT25    32'h0000_07ff
`define MSRG_M_13       32'h0000_1fff
`define MSRG_M_ADDR     32'h00ff_ffff
`define MSRG_M_SEL      32'h0000_000f
`define MSRG_M_BAD      32'h0000_01ff

// Control fields
`define MSRG_F_TYPE     2:0
`define MSRG_B_RTIME    3
`define MSRG_B_RPRE     4
`define MSRG_F_ENTRY    7:5
`define MSRG_B_ALT25    8
`define MSRG_F_POS      3:0
`define MSRG_F_WID      8:4
`define MSRG_F_TOW      15:10

// Emitter types
`define MSRG_T_OFF      3'h0
`define MSRG_T_BCN      3'h1
`define MSRG_T_S56      3'h2
`define MSRG_T_S112     3'h3
`define MSRG_T_PULSE    3'h4
`define MSRG_T_SQUIT    3'h5

// Entry selections
`define MSRG_E_RAW      3'h0
`define MSRG_E_ALLCALL  3'h1
`define MSRG_E_IDENT    3'h2
`define MSRG_E_ALT      3'h3
`define MSRG_E_RAND     3'h4
`define MSRG_E_ACFT     3'h5

// Message constants
`define MSRG_DF_ALLCALL 5'h0b
`define MSRG_DF_IDENT   5'h05
`define MSRG_DF_ALT     5'h04
`define MSRG_DF_ES      5'h11
`define MSRG_DF_ES_MAX  5'h13
`define MSRG_CA_DEF     3'h5
`define MSRG_POLY       24'hfff409
`define MSRG_LFSR_SEED  64'h5a5a_1234_c3c3_0f0f
`define MSRG_STORE_LAST 4'h8

// Timing
`define MSRG_CLK_NS     100
`define MSRG_CHIP_NS    500
`define MSRG_BIT_NS     1000
`define MSRG_PRE_NS     8000
`define MSRG_PRE2_NS    1000
`define MSRG_PRE3_NS    3500
`define MSRG_PRE4_NS    4500
`define MSRG_BCN_SP_NS  1450
`define MSRG_BCN_W_NS   450
`define MSRG_BCN_END_NS 22000
`define MSRG_DLY_MAX_US 1600
`define MSRG_TOW_MAX_NS 5000
`define MSRG_CHIP_CYC   (`MSRG_CHIP_NS / `MSRG_CLK_NS)
`define MSRG_BIT_CYC    (`MSRG_BIT_NS / `MSRG_CLK_NS)
`define MSRG_PRE_CYC    (`MSRG_PRE_NS / `MSRG_CLK_NS)
`define MSRG_BCN_W_CYC  (`MSRG_BCN_W_NS / `MSRG_CLK_NS)
`define MSRG_BCN_END    (`MSRG_BCN_END_NS / `MSRG_CLK_NS)
`define MSRG_DLY_MAXC   (`MSRG_DLY_MAX_US * 1000 / `MSRG_CLK_NS)
`define MSRG_TOW_MAXC   (`MSRG_TOW_MAX_NS / `MSRG_CLK_NS)

`endif

// *** hw/msrg_core.v ***
// Functional notes
// - Fixed timing: start a programmed delay of 0 to 1600 us after trigger.
// - Random timing: start at a random instant between minimum and maximum delay.
// - Types beacon, 56-bit, 112-bit, pulse, squitter or off; off emits nothing.
// - Beacon code comes from entered code, altitude code or a random value.
// - Beacon pulse spacing shifts within +/-250 ns in 50 ns steps; logic truncates the shift to 100 ns clock steps.
// - Beacon pulse width changes +750 to -250 ns in 50 ns steps; logic truncates the change to 100 ns clock steps.
// - Mode S parity is computed and inserted for 56 and 112 bit messages.
// - 56-bit raw mode sends loaded DF, data and AP fields unchecked.
// - All-call mode builds format 11 message with aircraft address.
// - Identity mode builds format 5 message with identity and address.
// - Altitude mode builds format 4 message, 25 or 100 foot coding.
// - Full preamble setting sends all four preamble pulses.
// - Random preamble drops at most one pulse; 50% full, 12.5% each.
// - Preamble spacing +/-250 ns, width +750/-250 ns, 50 ns steps; logic truncates both to 100 ns clock steps.
// - 112-bit raw sends loaded fields; alert when DF not 17 to 19.
// - Random 112-bit mode randomises 56 data bits, keeps DF, CA and address; random 56-bit mode randomises all 32 bits.
// - Bad bit positions are numbered 1 through 112.
// - Inverted bad bit puts its pulse in the opposite chip.
// - Dropped bad bit sends no pulse in either chip.
// - Up to eight bad bits; parity computed from clean data.
// - Nine stored 112-bit messages; only the selected one is sent.
// - One trigger-out pulse per transmission, 0.1 to 5.0 us wide.
// - Triggers arriving while busy are ignored and flag a conflict.
`timescale 1ns/1ps
`include "msrg_defs.vh"

module msrg_core (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // AXI4-Lite write channels
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read channels
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Trigger and modulator side
  input  wire        trig_in,
  output wire        rf_pulse,
  output wire        trig_out,
  output wire        trig_conflict,
  output wire        noncompliant,
  output wire        busy
);

  localparam [4:0] ST_IDLE  = 5'b00001;
  localparam [4:0] ST_DLY   = 5'b00010;
  localparam [4:0] ST_PRE   = 5'b00100;
  localparam [4:0] ST_DATA  = 5'b01000;
  localparam [4:0] ST_FRAME = 5'b10000;

  // Timing limits cut to the width of the counters they load
  localparam integer DLY_LIM_I  = `MSRG_DLY_MAXC;
  localparam integer TOW_LIM_I  = `MSRG_TOW_MAXC;
  localparam integer BCN_LAST_I = `MSRG_BCN_END - 1;
  localparam [13:0]  DLY_LIM    = DLY_LIM_I[13:0];
  localparam [5:0]   TOW_LIM    = TOW_LIM_I[5:0];
  localparam [15:0]  BCN_LAST   = BCN_LAST_I[15:0];

  reg  [31:0]  cfg_reg [0:10];
  reg  [31:0]  raw_reg [0:3];
  reg  [31:0]  bad_reg [0:7];
  reg  [31:0]  store_mem [0:35];
  reg          aw_got_reg;
  reg          w_got_reg;
  reg  [11:0]  awaddr_reg;
  reg  [31:0]  wdata_reg;
  reg  [3:0]   wstrb_reg;
  reg          bvalid_reg;
  reg  [1:0]   bresp_reg;
  reg          rvalid_reg;
  reg  [31:0]  rdata_reg;
  reg  [1:0]   rresp_reg;
  reg  [4:0]   st_reg;
  reg  [13:0]  dly_reg;
  reg  [15:0]  t_reg;
  reg  [6:0]   bit_reg;
  reg  [3:0]   sub_reg;
  reg  [5:0]   tow_reg;
  reg  [111:0] msg_reg;
  reg          long_reg;
  reg  [2:0]   typ_reg;
  reg  [11:0]  bcn_reg;
  reg  [2:0]   drop_reg;
  reg          conflict_reg;
  reg          nc_reg;
  reg          trig_d_reg;
  reg          rf_pulse_reg;
  reg          trig_out_reg;
  reg  [63:0]  lfsr_reg;
  reg  [111:0] msg_next;
  reg          long_next;
  reg  [11:0]  bcn_next;
  reg          lvl;
  reg  [31:0]  rd_data;
  reg          rd_ok;
  integer      k;
  integer      pos_c;
  integer      wid_c;
  integer      st_c;
  integer      tt;
  integer      ri;

  function [31:0] wmerge(input [31:0] o, input [31:0] d, input [3:0] s);
    integer b;
    begin
      for (b = 0; b < 4; b = b + 1)
        wmerge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction

  function [31:0] cfg_mask(input [3:0] i);
    begin
      case (i)
        4'h0: cfg_mask = `MSRG_M_CTRL;
        4'h1, 4'h2, 4'h4: cfg_mask = `MSRG_M_DLY;
        4'h3: cfg_mask = `MSRG_M_SHAPE;
        4'h5: cfg_mask = `MSRG_M_CODE;
        4'h6: cfg_mask = `MSRG_M_ALT25;
        4'h8: cfg_mask = `MSRG_M_ADDR;
        4'ha: cfg_mask = `MSRG_M_SEL;
        default: cfg_mask = `MSRG_M_13;
      endcase
    end
  endfunction

  // Parity over the clean message; short messages sit in the top 32 bits
  function [23:0] ms_crc(input [87:0] d, input lng);
    integer i;
    reg     fb;
    begin
      ms_crc = 24'h0;
      for (i = 0; i < 88; i = i + 1)
        if (lng || i < 32) begin
          fb     = ms_crc[23] ^ d[87-i];
          ms_crc = {ms_crc[22:0], 1'b0} ^ (fb ? `MSRG_POLY : 24'h0);
        end
    end
  endfunction

  // Register bus decode
  wire        wr_fire   = aw_got_reg && w_got_reg && !bvalid_reg;
  wire        ar_fire   = s_axi_arvalid && !rvalid_reg;
  wire [11:0] wa        = awaddr_reg;
  wire        wa_cfg    = wa < `MSRG_STATUS;
  wire        wa_stat   = wa[11:2] == `MSRG_STATUS >> 2;
  wire        wa_trig   = wa[11:2] == `MSRG_TRIG >> 2;
  wire        wa_raw    = wa[11:4] == `MSRG_RAW >> 4;
  wire        wa_bad    = wa[11:5] == `MSRG_BAD >> 5;
  wire        wa_store  = wa >= `MSRG_STORE && wa < `MSRG_STORE_END;
  wire        wa_ok     = wa_cfg | wa_stat | wa_trig | wa_raw | wa_bad | wa_store;
  wire [5:0]  wa_si     = wa[7:2];
  wire        stat_clr  = wr_fire && wa_stat && wstrb_reg[0] && wdata_reg[1];
  wire        soft_trig = wr_fire && wa_trig && wstrb_reg[0] && wdata_reg[0];

  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready  = !w_got_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= 2'h0;
      for (ri = 0; ri < 11; ri = ri + 1)
        cfg_reg[ri] <= 32'h0000_0000;
      for (ri = 0; ri < 4; ri = ri + 1)
        raw_reg[ri] <= 32'h0000_0000;
      for (ri = 0; ri < 8; ri = ri + 1)
        bad_reg[ri] <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= wa_ok ? 2'h0 : 2'h2;
        if (wa_cfg)
          cfg_reg[wa[5:2]] <= wmerge(cfg_reg[wa[5:2]], wdata_reg, wstrb_reg) & cfg_mask(wa[5:2]);
        if (wa_raw)
          raw_reg[wa[3:2]] <= wmerge(raw_reg[wa[3:2]], wdata_reg, wstrb_reg);
        if (wa_bad)
          bad_reg[wa[4:2]] <= wmerge(bad_reg[wa[4:2]], wdata_reg, wstrb_reg) & `MSRG_M_BAD;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (ar_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_data;
        rresp_reg  <= rd_ok ? 2'h0 : 2'h2;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Message store is plain memory with no reset
  always @(posedge ref_clk) begin
    if (wr_fire && wa_store)
      store_mem[wa_si] <= wmerge(store_mem[wa_si], wdata_reg, wstrb_reg);
  end

  always @* begin
    rd_ok   = 1'b1;
    rd_data = 32'h0000_0000;
    if (s_axi_araddr < `MSRG_STATUS)
      rd_data = cfg_reg[s_axi_araddr[5:2]];
    else if (s_axi_araddr[11:2] == `MSRG_STATUS >> 2)
      rd_data = {29'h0, nc_reg, conflict_reg, busy};
    else if (s_axi_araddr[11:2] == `MSRG_TRIG >> 2)
      rd_data = 32'h0000_0000;
    else if (s_axi_araddr[11:4] == `MSRG_RAW >> 4)
      rd_data = raw_reg[s_axi_araddr[3:2]];
    else if (s_axi_araddr[11:5] == `MSRG_BAD >> 5)
      rd_data = bad_reg[s_axi_araddr[4:2]];
    else if (s_axi_araddr >= `MSRG_STORE && s_axi_araddr < `MSRG_STORE_END)
      rd_data = store_mem[s_axi_araddr[7:2]];
    else
      rd_ok = 1'b0;
  end

  wire [31:0]  ctrl     = cfg_reg[0];
  wire [2:0]   typ      = ctrl[`MSRG_F_TYPE];
  wire [2:0]   entry    = ctrl[`MSRG_F_ENTRY];
  wire [23:0]  aa       = cfg_reg[8][23:0];
  wire [10:0]  alt_n    = cfg_reg[6][10:0];
  wire [12:0]  ac13     = ctrl[`MSRG_B_ALT25] ? {alt_n[10:5], 1'b0, alt_n[4], 1'b1, alt_n[3:0]}
                                              : cfg_reg[7][12:0];
  wire [3:0]   sel      = cfg_reg[10][3:0] > `MSRG_STORE_LAST ? `MSRG_STORE_LAST : cfg_reg[10][3:0];
  wire [5:0]   sbase    = {sel, 2'b00};
  wire [13:0]  dmin     = cfg_reg[1][13:0];
  wire [13:0]  dmax     = cfg_reg[2][13:0];
  wire [14:0]  span1    = (dmax > dmin) ? {1'b0, dmax - dmin} + 15'h0001 : 15'h0001;
  wire [28:0]  rprod    = lfsr_reg[13:0] * span1;
  wire [13:0]  dly_next = ctrl[`MSRG_B_RTIME] ? dmin + rprod[27:14] : dmin;
  wire [23:0]  par      = ms_crc(long_next ? msg_next[111:24] : {msg_next[111:80], 56'h0}, long_next);
  wire [111:0] msg_fin  = long_next ? {msg_next[111:24], msg_next[23:0] ^ par}
                                    : {msg_next[111:80], msg_next[79:56] ^ par, 56'h0};
  wire         trig_any = (trig_in && !trig_d_reg) || soft_trig;
  wire         accept   = trig_any && st_reg == ST_IDLE && typ != `MSRG_T_OFF;
  wire         nc_next  = typ == `MSRG_T_S112 && entry == `MSRG_E_RAW &&
                          (raw_reg[0][31:27] < `MSRG_DF_ES || raw_reg[0][31:27] > `MSRG_DF_ES_MAX);
  wire [5:0]   tow_f    = cfg_reg[3][`MSRG_F_TOW];
  wire [5:0]   tow_w    = tow_f == 6'h00 ? 6'h01 : (tow_f > TOW_LIM ? TOW_LIM : tow_f);
  wire [15:0]  pw       = cfg_reg[4][15:0];
  wire [15:0]  fr_last  = typ_reg == `MSRG_T_PULSE ? (pw == 16'h0 ? 16'h0 : pw - 16'h1) : BCN_LAST;
  wire [6:0]   bit_pos  = bit_reg + 7'h01;
  wire [14:0]  bcn_bits = {1'b1, bcn_reg[2], bcn_reg[8], bcn_reg[1], bcn_reg[7], bcn_reg[0], bcn_reg[6], 1'b0,
                           bcn_reg[11], bcn_reg[5], bcn_reg[10], bcn_reg[4], bcn_reg[9], bcn_reg[3], 1'b1};
  wire [7:0]   inv_hit;
  wire [7:0]   drop_hit;

  // Slot match against the current 1-based bit position
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_bad
      assign inv_hit[g]  = bad_reg[g][8] && !bad_reg[g][7] && bad_reg[g][6:0] == bit_pos;
      assign drop_hit[g] = bad_reg[g][8] && bad_reg[g][7] && bad_reg[g][6:0] == bit_pos;
    end
  endgenerate

  // Message assembly; the low 24 bits are xor-ed with the parity
  always @* begin
    msg_next  = 112'h0;
    long_next = 1'b0;
    bcn_next  = cfg_reg[5][11:0];
    case (entry)
      `MSRG_E_ALT:  bcn_next = cfg_reg[7][11:0];
      `MSRG_E_RAND: bcn_next = lfsr_reg[11:0];
      default:      bcn_next = cfg_reg[5][11:0];
    endcase
    if (typ == `MSRG_T_S56) begin
      case (entry)
        `MSRG_E_RAW:     msg_next[111:56] = {raw_reg[0], raw_reg[1][31:8]};
        `MSRG_E_ALLCALL: msg_next[111:56] = {`MSRG_DF_ALLCALL, `MSRG_CA_DEF, aa, 24'h0};
        `MSRG_E_IDENT:   msg_next[111:56] = {`MSRG_DF_IDENT, 14'h0, cfg_reg[9][12:0], aa};
        `MSRG_E_ALT:     msg_next[111:56] = {`MSRG_DF_ALT, 14'h0, ac13, aa};
        default:         msg_next[111:56] = {lfsr_reg[55:24], 24'h0};
      endcase
    end else if (typ == `MSRG_T_S112 || typ == `MSRG_T_SQUIT) begin
      long_next = 1'b1;
      if (typ == `MSRG_T_SQUIT || entry == `MSRG_E_ACFT)
        msg_next = {store_mem[sbase], store_mem[sbase+6'h1], store_mem[sbase+6'h2],
                    store_mem[sbase+6'h3][31:16]};
      else if (entry == `MSRG_E_RAND)
        msg_next = {`MSRG_DF_ES, `MSRG_CA_DEF, aa, lfsr_reg[55:0], 24'h0};
      else
        msg_next = {raw_reg[0], raw_reg[1], raw_reg[2], raw_reg[3][31:16]};
    end
  end

  // Pulse level for the current cycle
  always @* begin
    lvl   = 1'b0;
    tt    = t_reg;
    pos_c = $signed(cfg_reg[3][`MSRG_F_POS]) / 2;
    wid_c = $signed(cfg_reg[3][`MSRG_F_WID]) / 2;
    st_c  = 0;
    case (st_reg)
      ST_PRE: begin
        for (k = 0; k < 4; k = k + 1) begin
          st_c = (k == 0 ? 0 : k == 1 ? `MSRG_PRE2_NS : k == 2 ? `MSRG_PRE3_NS : `MSRG_PRE4_NS) / `MSRG_CLK_NS
                 + k * pos_c;
          if (!(drop_reg[2] && drop_reg[1:0] == k[1:0]) && tt >= st_c
              && tt < st_c + `MSRG_CHIP_CYC + wid_c)
            lvl = 1'b1;
        end
      end
      ST_DATA: begin
        if (drop_hit == 8'h00)
          lvl = (msg_reg[7'd111 - bit_reg] ^ (inv_hit != 8'h00)) ? sub_reg < `MSRG_CHIP_CYC
                                                                  : sub_reg >= `MSRG_CHIP_CYC;
      end
      ST_FRAME: begin
        if (typ_reg == `MSRG_T_PULSE)
          lvl = 1'b1;
        else begin
          for (k = 0; k < 15; k = k + 1) begin
            st_c = k * `MSRG_BCN_SP_NS / `MSRG_CLK_NS + k * pos_c;
            if (bcn_bits[k] && tt >= st_c && tt < st_c + `MSRG_BCN_W_CYC + wid_c)
              lvl = 1'b1;
          end
        end
      end
      default: lvl = 1'b0;
    endcase
  end

  // Sequencer
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg       <= ST_IDLE;
      dly_reg      <= 14'h0;
      t_reg        <= 16'h0;
      bit_reg      <= 7'h0;
      sub_reg      <= 4'h0;
      tow_reg      <= 6'h0;
      msg_reg      <= 112'h0;
      long_reg     <= 1'b0;
      typ_reg      <= `MSRG_T_OFF;
      bcn_reg      <= 12'h0;
      drop_reg     <= 3'h0;
      conflict_reg <= 1'b0;
      nc_reg       <= 1'b0;
      trig_d_reg   <= 1'b0;
      rf_pulse_reg <= 1'b0;
      trig_out_reg <= 1'b0;
      lfsr_reg     <= `MSRG_LFSR_SEED;
    end else begin
      lfsr_reg     <= {lfsr_reg[62:0], lfsr_reg[63] ^ lfsr_reg[62] ^ lfsr_reg[60] ^ lfsr_reg[59]};
      trig_d_reg   <= trig_in;
      nc_reg       <= nc_next;
      rf_pulse_reg <= lvl;
      conflict_reg <= (conflict_reg && !stat_clr) || (trig_any && st_reg != ST_IDLE);
      if (tow_reg != 6'h0)
        tow_reg <= tow_reg - 6'h1;
      trig_out_reg <= tow_reg > 6'h1;
      case (st_reg)
        ST_IDLE: begin
          if (accept) begin
            st_reg   <= ST_DLY;
            dly_reg  <= dly_next > DLY_LIM ? DLY_LIM : dly_next;
            msg_reg  <= msg_fin;
            long_reg <= long_next;
            typ_reg  <= typ;
            bcn_reg  <= bcn_next;
            drop_reg <= ctrl[`MSRG_B_RPRE] ? lfsr_reg[63:61] : 3'h0;
          end
        end
        ST_DLY: begin
          if (dly_reg == 14'h0) begin
            t_reg        <= 16'h0;
            tow_reg      <= tow_w;
            trig_out_reg <= 1'b1;
            st_reg       <= (typ_reg == `MSRG_T_BCN || typ_reg == `MSRG_T_PULSE) ? ST_FRAME : ST_PRE;
          end else
            dly_reg <= dly_reg - 14'h1;
        end
        ST_PRE: begin
          t_reg <= t_reg + 16'h1;
          if (t_reg == `MSRG_PRE_CYC - 1) begin
            st_reg  <= ST_DATA;
            bit_reg <= 7'h0;
            sub_reg <= 4'h0;
          end
        end
        ST_DATA: begin
          sub_reg <= sub_reg + 4'h1;
          if (sub_reg == `MSRG_BIT_CYC - 1) begin
            sub_reg <= 4'h0;
            if (bit_reg == (long_reg ? 7'd111 : 7'd55))
              st_reg <= ST_IDLE;
            else
              bit_reg <= bit_reg + 7'h1;
          end
        end
        ST_FRAME: begin
          t_reg <= t_reg + 16'h1;
          if (t_reg == fr_last)
            st_reg <= ST_IDLE;
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  assign rf_pulse      = rf_pulse_reg;
  assign trig_out      = trig_out_reg;
  assign trig_conflict = conflict_reg;
  assign noncompliant  = nc_reg;
  assign busy          = st_reg != ST_IDLE;

endmodule

// *** tb/msrg_checker.sv ***
`timescale 1ns/1ps
module msrg_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Sequencer side
  input wire logic rf_pulse,
  input wire logic trig_out,
  input wire logic trig_conflict,
  input wire logic busy
);
  logic [6:0] tow_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence b_take; s_axi_bvalid && s_axi_bready; endsequence
  // Length of the current trigger-out pulse
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) tow_cnt <= 7'h00;
    else tow_cnt <= trig_out ? tow_cnt + 7'h01 : 7'h00;
  end
  pulse_in_frame_a: assert property (rf_pulse |-> busy || $past(busy))
    else $error("rf pulse outside a transmission");
  conflict_cause_a: assert property ($rose(trig_conflict) |-> $past(busy) || $past(busy, 2))
    else $error("conflict flag without busy trigger");
  conflict_clear_a: assert property ($fell(trig_conflict) |-> $rose(s_axi_bvalid))
    else $error("conflict flag dropped without a write");
  trigout_start_a: assert property ($rose(trig_out) |-> busy && $past(busy))
    else $error("trigger out outside a transmission");
  trigout_width_a: assert property (tow_cnt <= 7'd50)
    else $error("trigger out too wide");
  read_answer_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("read data late");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  write_answer_a: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready, 2))
    else $error("write response without a transfer");
  b_release_a: assert property (b_take |=> !s_axi_bvalid)
    else $error("write response held after handshake");
endmodule

bind msrg_core msrg_checker chk (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .rf_pulse(rf_pulse),
  .trig_out(trig_out), .trig_conflict(trig_conflict), .busy(busy));

// *** tb/msrg_modulator.sv ***
`timescale 1ns/1ps
module msrg_modulator (
  // Modulator inputs
  input  wire logic       ref_clk,
  input  wire logic       rf_pulse,
  input  wire logic       trig_out,
  // Decoded chip pairs
  output logic            sym_valid,
  output logic [1:0]      sym
);
  integer t;
  logic   trig_d;
  logic   chip1;
  initial begin
    t = -1;
    trig_d = 1'b0;
    chip1 = 1'b0;
    sym_valid = 1'b0;
    sym = 2'b00;
  end
  // Mid-chip sampling, bit slots start 80 cycles after the frame mark
  always @(posedge ref_clk) begin
    sym_valid <= 1'b0;
    trig_d <= trig_out;
    if (trig_out && !trig_d) t = 0;
    else if (t >= 0 && t < 1300) t = t + 1;
    if (t >= 80 && t < 1200 && (t - 80) % 10 == 3) chip1 <= rf_pulse;
    if (t >= 80 && t < 1200 && (t - 80) % 10 == 8) begin
      sym_valid <= 1'b1;
      sym <= {chip1, rf_pulse};
    end
  end
endmodule

// *** tb/msrg_core_bench.sv ***
`timescale 1ns/1ps
`include "msrg_defs.vh"
module msrg_core_bench;
  logic ref_clk, rst_n, trig_in, rf_pulse, trig_out, trig_conflict, noncompliant, busy;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, aa;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sym_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, sym, r;
  logic [33:0] sq[$], rq[$], n;
  logic [55:0] m;
  logic [13:0] d;
  logic [4:0] dfs[5] = '{5'd1, 5'd17, 5'd18, 5'd19, 5'd20};
  integer fails = 0, checks = 0, seed, k;
  msrg_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .trig_in(trig_in),
    .rf_pulse(rf_pulse), .trig_out(trig_out), .trig_conflict(trig_conflict), .noncompliant(noncompliant),
    .busy(busy));
  msrg_modulator mod (.ref_clk(ref_clk), .rf_pulse(rf_pulse), .trig_out(trig_out), .sym_valid(sym_valid),
    .sym(sym));
  task automatic chk(input [33:0] g, input [33:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input [11:0] a, input [31:0] v, output [1:0] resp);
    @(posedge ref_clk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    fork
      begin do @(posedge ref_clk); while (!s_axi_awready); s_axi_awvalid <= 0; end
      begin do @(posedge ref_clk); while (!s_axi_wready); s_axi_wvalid <= 0; end
    join
    while (!s_axi_bvalid) @(posedge ref_clk);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input [11:0] a, input [33:0] e);
    rq.push_back(e);
    @(posedge ref_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid) @(posedge ref_clk);
    s_axi_rready <= 0;
  endtask
  task automatic fire;
    @(posedge ref_clk) trig_in <= 1;
    @(posedge ref_clk) trig_in <= 0;
  endtask
  function automatic [23:0] par(input [31:0] v);
    logic [23:0] c;
    c = 0;
    for (int i = 31; i >= 0; i--) c = {c[22:0], 1'b0} ^ ((c[23] ^ v[i]) ? `MSRG_POLY : 24'h0);
    return c;
  endfunction
  // Result watcher: oldest note against each read answer, and against each symbol while notes remain queued
  always @(posedge ref_clk) begin
    if (sym_valid && sq.size() > 0) chk(sym, sq.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end
  task conclude;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    #(40000 * 100);
    fails++;
    conclude;
  end
  initial begin
    seed = 32'h636d;
    {rst_n, trig_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1;
    rd(`MSRG_CTRL, 34'h0);
    wr(`MSRG_DLY_MIN, 32'hffff_ffff, r);
    rd(`MSRG_DLY_MIN, {2'b00, `MSRG_M_DLY});
    wr(12'h034, 32'h1, r);
    chk(r, 2'b10);
    rd(12'h034, {2'b10, 32'h0});
    fire;
    repeat (30) @(posedge ref_clk);
    chk(busy, 1'b0);
    aa = $random(seed) & `MSRG_M_ADDR;
    d = $random(seed) & 14'h3f;
    m = {`MSRG_DF_ALLCALL, `MSRG_CA_DEF, aa[23:0], par({`MSRG_DF_ALLCALL, `MSRG_CA_DEF, aa[23:0]})};
    wr(`MSRG_ADDR, aa, r);
    wr(`MSRG_DLY_MIN, {18'h0, d}, r);
    wr(`MSRG_CTRL, {24'h0, `MSRG_E_ALLCALL, 2'b00, `MSRG_T_S56}, r);
    for (k = 0; k < 2; k++) begin
      if (k == 1) wr(`MSRG_BAD, 32'h103, r);
      if (k == 1) wr(`MSRG_BAD + 12'h4, 32'h1a8, r);
      for (int b = 1; b <= 56; b++)
        sq.push_back(k && b == 40 ? 2'b00 : (m[56 - b] ^ (k && b == 3)) ? 2'b10 : 2'b01);
      fire;
      n = 0;
      while (!trig_out) begin
        @(posedge ref_clk);
        n++;
      end
      chk(n, d + 14'd2);
      fire;
      while (busy) @(posedge ref_clk);
      chk(trig_conflict, 1'b1);
      rd(`MSRG_STATUS, 34'h2);
      wr(`MSRG_STATUS, 32'h2, r);
      rd(`MSRG_STATUS, 34'h0);
      repeat (700) @(posedge ref_clk);
      chk(sq.size(), 0);
    end
    wr(`MSRG_CTRL, {29'h0, `MSRG_T_S112}, r);
    foreach (dfs[i]) begin
      wr(`MSRG_RAW, {dfs[i], 27'h0}, r);
      repeat (2) @(posedge ref_clk);
      chk(noncompliant, (dfs[i] < 17 || dfs[i] > 19));
    end
    conclude;
  end
endmodule
